// File: src/vin_fault_supervisor.sv
`timescale 1ns/1ps
// Functional notes
// - An input over-voltage warning limit is held and compared with vin.
// - The under-voltage warning limit also drives the ratio threshold.
// - Below the under-voltage fault limit the programmed action applies.
// - Action code 00 keeps the output running through the fault.
// - Code 01 runs for the delay, then follows the retry field if the fault persists.
// - Code 10 disables the output at once and follows the retry field.
// - Code 11 latches off until a clear, reset, off-on cycle or other_fault.
// - Retry code 000 makes no restart and stays off until cleared.
// - Retry codes 1 to 6 allow that many restarts, then latch off.
// - Restart attempts start one delay interval apart.
// - Retry code 111 restarts without limit until turned off.
// - The delay field selects a multiplier of two to the field value.
// - The time base comes from a separate time-unit input.
// - Power good asserts when vout is at or above the on threshold.
// - Below the off threshold power good drops and its status sets.
module vin_fault_supervisor
	import vin_sup_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// command port from the bus front end
	input cmd_req_t req,
	output logic [15:0] rdata,
	output logic rvalid,
	// measured values (same clock domain)
	input wire logic [15:0] vin,
	input wire logic [15:0] vout,
	// time base from the time-unit register
	input wire logic [TICK_W-1:0] unit_cycles,
	// options
	input wire logic ratio_reg_enable,
	input wire logic pg_pin_enable,
	// control pin, raw
	input wire logic ctrl_pin,
	input wire logic on_cmd,
	// fault clearing
	input wire logic clear_faults,
	input wire logic clear_uv_fault_bit,
	input wire logic other_fault,
	// outputs
	output logic output_enable,
	output logic output_good_signal,
	output logic ratio_mode_active,
	output logic ov_warn_flag,
	output logic uv_warn_flag,
	output logic uv_fault_flag,
	output logic pg_status_flag,
	output logic latched_off
);
	// ==================================================
	// state
	typedef struct packed {
		logic [1:0] ctrl_sync;
		logic on_prev;
		fault_state_t fsm;
		logic [2:0] tries;
		logic ov_warn;
		logic uv_warn;
		logic uv_fault;
		logic pg;
		logic pg_stat;
		logic ratio;
	} st_t;
	st_t st_ff;
	st_t nxt_st;

	limits_t lim;
	logic tmr_start;
	logic tmr_done;
	logic turned_on;
	logic is_on;
	logic vin_ov;
	logic vin_uv_w;
	logic vin_uv_f;
	logic [1:0] resp;
	logic [2:0] retry;
	logic clear_ev;

	// ==================================================
	// submodules
	limit_regs u_regs (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.req(req),
		.rdata(rdata),
		.rvalid(rvalid),
		.lim(lim)
	);

	unit_timer u_tmr (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.start(tmr_start),
		.unit_cycles(unit_cycles),
		.dly_field(lim.uv_action[DLY_HI:DLY_LO]),
		.done(tmr_done)
	);

	// ==================================================
	// comparisons
	assign vin_ov = vin > lim.ov_warn;
	assign vin_uv_w = vin < lim.uv_warn;
	assign vin_uv_f = vin < lim.uv_fault;
	assign resp = lim.uv_action[RESP_HI:RESP_LO];
	assign retry = lim.uv_action[RETRY_HI:RETRY_LO];
	assign is_on = st_ff.ctrl_sync[1] & on_cmd;
	assign turned_on = is_on & ~st_ff.on_prev;

	// ==================================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		tmr_start = 1'b0;
		nxt_st.ctrl_sync = {st_ff.ctrl_sync[0], ctrl_pin};
		nxt_st.on_prev = is_on;
		// warning flags, set wins over clear
		if (clear_faults) begin
			nxt_st.ov_warn = 1'b0;
			nxt_st.uv_warn = 1'b0;
			nxt_st.pg_stat = 1'b0;
		end
		if (vin_ov) begin
			nxt_st.ov_warn = 1'b1;
		end
		if (vin_uv_w) begin
			nxt_st.uv_warn = 1'b1;
		end
		nxt_st.ratio = ratio_reg_enable & ~vin_uv_w;
		// power good hysteresis
		if (vout >= lim.pg_on) begin
			nxt_st.pg = 1'b1;
		end else if (vout < lim.pg_off) begin
			nxt_st.pg = 1'b0;
			nxt_st.pg_stat = 1'b1;
		end
		// fault flag clear, set wins
		clear_ev = clear_faults | clear_uv_fault_bit | turned_on;
		if (clear_ev) begin
			nxt_st.uv_fault = 1'b0;
		end
		if (vin_uv_f) begin
			nxt_st.uv_fault = 1'b1;
		end
		// fault response machine
		if (!is_on || other_fault) begin
			nxt_st.fsm = ST_RUN;
			nxt_st.tries = 3'h0;
		end else begin
			case (st_ff.fsm)
				ST_RUN: begin
					if (vin_uv_f) begin
						case (resp)
							RESP_IGNORE: nxt_st.fsm = ST_RUN;
							RESP_DELAY: begin
								nxt_st.fsm = ST_GRACE;
								tmr_start = 1'b1;
							end
							RESP_RETRY: begin
								if (retry == RETRY_NONE) begin
									nxt_st.fsm = ST_LATCHED;
								end else begin
									nxt_st.fsm = ST_WAIT;
									tmr_start = 1'b1;
								end
							end
							default: nxt_st.fsm = ST_LATCHED;
						endcase
					end
				end
				ST_GRACE: begin
					if (tmr_done) begin
						if (!vin_uv_f) begin
							nxt_st.fsm = ST_RUN;
						end else if (retry == RETRY_NONE) begin
							nxt_st.fsm = ST_LATCHED;
						end else begin
							nxt_st.fsm = ST_WAIT;
							tmr_start = 1'b1;
						end
					end
				end
				ST_WAIT: begin
					if (tmr_done) begin
						if (retry != RETRY_FOREVER && st_ff.tries >= retry) begin
							nxt_st.fsm = ST_LATCHED;
						end else begin
							nxt_st.fsm = ST_RESTART;
							if (retry != RETRY_FOREVER) begin
								nxt_st.tries = st_ff.tries + 3'h1;
							end
							tmr_start = 1'b1;
						end
					end
				end
				ST_RESTART: begin
					if (vin_uv_f) begin
						nxt_st.fsm = ST_WAIT;
					end else if (tmr_done) begin
						nxt_st.fsm = ST_RUN;
						nxt_st.tries = 3'h0;
					end
				end
				ST_LATCHED: begin
					if (clear_faults || clear_uv_fault_bit) begin
						nxt_st.fsm = ST_RUN;
						nxt_st.tries = 3'h0;
					end
				end
				default: nxt_st.fsm = ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '{ctrl_sync: 2'b00, on_prev: 1'b0, fsm: ST_RUN,
				tries: 3'h0, ov_warn: 1'b0, uv_warn: 1'b0, uv_fault: 1'b0,
				pg: 1'b0, pg_stat: 1'b0, ratio: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==================================================
	// outputs
	assign output_enable = is_on && !other_fault
		&& (st_ff.fsm == ST_RUN || st_ff.fsm == ST_GRACE
		|| st_ff.fsm == ST_RESTART);
	assign output_good_signal = pg_pin_enable & st_ff.pg;
	assign ratio_mode_active = st_ff.ratio;
	assign ov_warn_flag = st_ff.ov_warn;
	assign uv_warn_flag = st_ff.uv_warn;
	assign uv_fault_flag = st_ff.uv_fault;
	assign pg_status_flag = st_ff.pg_stat;
	assign latched_off = st_ff.fsm == ST_LATCHED;
endmodule : vin_fault_supervisor

// File: src/vin_sup_pkg.sv
package vin_sup_pkg;
	// ==================================================
	// command codes
	localparam logic [7:0] CMD_OV_WARN = 8'h57;
	localparam logic [7:0] CMD_UV_WARN = 8'h58;
	localparam logic [7:0] CMD_UV_FAULT = 8'h59;
	localparam logic [7:0] CMD_UV_ACTION = 8'h5a;
	localparam logic [7:0] CMD_PG_ON = 8'h5e;
	localparam logic [7:0] CMD_PG_OFF = 8'h5f;
	// ==================================================
	// reset values
	localparam logic [15:0] RST_OV_WARN = 16'hffff;
	localparam logic [15:0] RST_UV_WARN = 16'h0000;
	localparam logic [15:0] RST_UV_FAULT = 16'h0000;
	localparam logic [7:0] RST_UV_ACTION = 8'h00;
	localparam logic [15:0] RST_PG_ON = 16'h0000;
	localparam logic [15:0] RST_PG_OFF = 16'h0000;
	// ==================================================
	// action field layout
	localparam int RESP_HI = 7;
	localparam int RESP_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DLY_HI = 2;
	localparam int DLY_LO = 0;
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_DELAY = 2'h1;
	localparam logic [1:0] RESP_RETRY = 2'h2;
	localparam logic [1:0] RESP_LATCH = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam int TICK_W = 16;
	localparam int MULT_W = 8;
	localparam int CNT_W = TICK_W + MULT_W;

	// ==================================================
	// carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] cmd;
		logic [15:0] wdata;
	} cmd_req_t;

	typedef struct packed {
		logic [15:0] ov_warn;
		logic [15:0] uv_warn;
		logic [15:0] uv_fault;
		logic [7:0] uv_action;
		logic [15:0] pg_on;
		logic [15:0] pg_off;
	} limits_t;

	typedef enum logic [2:0] {
		ST_RUN, ST_GRACE, ST_WAIT, ST_RESTART, ST_LATCHED
	} fault_state_t;

	// 2 to the power of the delay field
	function automatic logic [MULT_W-1:0] dly_mult(input logic [2:0] f);
		dly_mult = MULT_W'(1) << f;
	endfunction : dly_mult
endpackage : vin_sup_pkg

// File: src/limit_regs.sv
`timescale 1ns/1ps
module limit_regs
	import vin_sup_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// command port
	input cmd_req_t req,
	output logic [15:0] rdata,
	output logic rvalid,
	// held limits
	output limits_t lim
);
	typedef struct packed {
		limits_t lim;
		logic [15:0] rdata;
		logic rvalid;
	} st_t;
	st_t st_ff;
	st_t nxt_st;

	// ==================================================
	// write decode and read mux
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rvalid = req.rd;
		if (req.wr) begin
			case (req.cmd)
				CMD_OV_WARN: nxt_st.lim.ov_warn = req.wdata;
				CMD_UV_WARN: nxt_st.lim.uv_warn = req.wdata;
				CMD_UV_FAULT: nxt_st.lim.uv_fault = req.wdata;
				CMD_UV_ACTION: nxt_st.lim.uv_action = req.wdata[7:0];
				CMD_PG_ON: nxt_st.lim.pg_on = req.wdata;
				CMD_PG_OFF: nxt_st.lim.pg_off = req.wdata;
				default: ;
			endcase
		end
		if (req.rd) begin
			case (req.cmd)
				CMD_OV_WARN: nxt_st.rdata = st_ff.lim.ov_warn;
				CMD_UV_WARN: nxt_st.rdata = st_ff.lim.uv_warn;
				CMD_UV_FAULT: nxt_st.rdata = st_ff.lim.uv_fault;
				CMD_UV_ACTION: nxt_st.rdata = {8'h00, st_ff.lim.uv_action};
				CMD_PG_ON: nxt_st.rdata = st_ff.lim.pg_on;
				CMD_PG_OFF: nxt_st.rdata = st_ff.lim.pg_off;
				default: nxt_st.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '{lim: '{RST_OV_WARN, RST_UV_WARN, RST_UV_FAULT,
				RST_UV_ACTION, RST_PG_ON, RST_PG_OFF},
				rdata: 16'h0000, rvalid: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign lim = st_ff.lim;
	assign rdata = st_ff.rdata;
	assign rvalid = st_ff.rvalid;
endmodule : limit_regs

// File: src/unit_timer.sv
`timescale 1ns/1ps
module unit_timer
	import vin_sup_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control
	input wire logic start,
	input wire logic [TICK_W-1:0] unit_cycles,
	input wire logic [2:0] dly_field,
	// expiry pulse
	output logic done
);
	typedef struct packed {
		logic busy;
		logic [CNT_W-1:0] cnt;
		logic done;
	} st_t;
	st_t st_ff;
	st_t nxt_st;
	logic [CNT_W-1:0] total;

	// interval is multiplier times time unit, never below one cycle
	always_comb begin
		total = CNT_W'(unit_cycles) * CNT_W'(dly_mult(dly_field));
		if (total == '0) begin
			total = CNT_W'(1);
		end
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		// owner acts one edge after done, so done rises one cycle early
		if (start) begin
			nxt_st.busy = total > CNT_W'(1);
			nxt_st.cnt = total - CNT_W'(2);
			nxt_st.done = total == CNT_W'(1);
		end else if (st_ff.busy) begin
			if (st_ff.cnt == '0) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign done = st_ff.done;
endmodule : unit_timer

// File: sim/vin_host.sv
`timescale 1ns/1ps
module vin_host
	import vin_sup_pkg::*;
(
	// command side
	input wire logic clk_sys,
	input wire logic rvalid,
	input wire logic [15:0] rdata,
	output cmd_req_t req
);
	initial req = '0;
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk_sys);
		req <= '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
		@(negedge clk_sys);
		req.wr <= 1'b0;
	endtask : wr
	// answer stands one cycle, seen settled at the falling edge
	task automatic rd(input logic [7:0] c, output logic [15:0] d,
		output logic ok);
		@(negedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 16'h0000};
		ok = 1'b0;
		d = 16'h0000;
		for (int i = 0; i < 3 && !ok; i++) begin
			@(negedge clk_sys);
			req.rd <= 1'b0;
			if (rvalid === 1'b1) begin
				ok = 1'b1;
				d = rdata;
			end
		end
	endtask : rd
endmodule : vin_host

// File: sim/vin_sup_chk.sv
`timescale 1ns/1ps
module vin_sup_chk
	import vin_sup_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// inputs
	input cmd_req_t req,
	input wire logic ctrl_pin,
	input wire logic on_cmd,
	input wire logic clear_faults,
	input wire logic clear_uv_fault_bit,
	input wire logic other_fault,
	input wire logic ratio_reg_enable,
	input wire logic pg_pin_enable,
	// outputs
	input wire logic rvalid,
	input wire logic output_enable,
	input wire logic output_good_signal,
	input wire logic ratio_mode_active,
	input wire logic ov_warn_flag,
	input wire logic pg_status_flag,
	input wire logic latched_off
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence rd_take;
		req.rd;
	endsequence
	sequence rd_answer;
		##1 rvalid;
	endsequence
	sequence latch_kept;
		latched_off && on_cmd && ctrl_pin && $past(ctrl_pin)
			&& $past(ctrl_pin, 2) && !clear_faults
			&& !clear_uv_fault_bit && !other_fault;
	endsequence
	read_answer_a: assert property (rd_take |-> rd_answer)
		else $error("read not answered");
	answer_pulse_a: assert property (!req.rd |=> !rvalid)
		else $error("answer without read");
	latch_off_a: assert property (latched_off |-> !output_enable)
		else $error("output on while latched");
	fault_off_a: assert property
		(other_fault |-> !output_enable)
		else $error("output on during other fault");
	latch_hold_a: assert property (latch_kept |=> latched_off)
		else $error("latch left without clear");
	good_gate_a: assert property (output_good_signal |-> pg_pin_enable)
		else $error("power good while disabled");
	pg_sticky_a: assert property
		(pg_status_flag && !clear_faults |=> pg_status_flag)
		else $error("power good status lost");
	ov_sticky_a: assert property
		(ov_warn_flag && !clear_faults |=> ov_warn_flag)
		else $error("warning flag lost");
	ratio_gate_a: assert property
		(ratio_mode_active |-> $past(ratio_reg_enable))
		else $error("ratio mode without option");
endmodule : vin_sup_chk
bind vin_fault_supervisor vin_sup_chk u_chk (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.req(req),
	.ctrl_pin(ctrl_pin),
	.on_cmd(on_cmd),
	.clear_faults(clear_faults),
	.clear_uv_fault_bit(clear_uv_fault_bit),
	.other_fault(other_fault),
	.ratio_reg_enable(ratio_reg_enable),
	.pg_pin_enable(pg_pin_enable),
	.rvalid(rvalid),
	.output_enable(output_enable),
	.output_good_signal(output_good_signal),
	.ratio_mode_active(ratio_mode_active),
	.ov_warn_flag(ov_warn_flag),
	.pg_status_flag(pg_status_flag),
	.latched_off(latched_off)
);

// File: sim/test_vin_fault_supervisor.sv
`timescale 1ns/1ps
module test_vin_fault_supervisor
	import vin_sup_pkg::*;
;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	cmd_req_t req;
	logic [15:0] rdata, vin, vout;
	logic [TICK_W-1:0] unit_cycles;
	logic rvalid, ratio_reg_enable, pg_pin_enable, ctrl_pin, on_cmd;
	logic clear_faults, clear_uv_fault_bit, other_fault;
	logic output_enable, output_good_signal, ratio_mode_active;
	logic ov_warn_flag, uv_warn_flag, uv_fault_flag, pg_status_flag;
	logic latched_off;
	int n_mismatch = 0;
	int comparisons = 0;
	typedef struct {logic [7:0] c; logic [15:0] r, w, e;} row_t;
	// command, reset value, written, read back
	row_t rows [7] = '{
		'{CMD_OV_WARN, RST_OV_WARN, 16'h0a00, 16'h0a00},
		'{CMD_UV_WARN, RST_UV_WARN, 16'h0600, 16'h0600},
		'{CMD_UV_FAULT, RST_UV_FAULT, 16'h0400, 16'h0400},
		'{CMD_UV_ACTION, 16'(RST_UV_ACTION), 16'hffc5, 16'h00c5},
		'{CMD_PG_ON, RST_PG_ON, 16'h0300, 16'h0300},
		'{CMD_PG_OFF, RST_PG_OFF, 16'h0200, 16'h0200},
		'{8'h33, 16'h0000, 16'h1234, 16'h0000}
	};
	initial forever #5 clk_sys = ~clk_sys;
	vin_host host (.clk_sys(clk_sys), .rvalid(rvalid), .rdata(rdata),
		.req(req));
	vin_fault_supervisor uut (.clk_sys(clk_sys), .nrst(nrst), .req(req),
		.rdata(rdata), .rvalid(rvalid), .vin(vin), .vout(vout),
		.unit_cycles(unit_cycles), .ratio_reg_enable(ratio_reg_enable),
		.pg_pin_enable(pg_pin_enable), .ctrl_pin(ctrl_pin),
		.on_cmd(on_cmd), .clear_faults(clear_faults),
		.clear_uv_fault_bit(clear_uv_fault_bit),
		.other_fault(other_fault), .output_enable(output_enable),
		.output_good_signal(output_good_signal),
		.ratio_mode_active(ratio_mode_active),
		.ov_warn_flag(ov_warn_flag), .uv_warn_flag(uv_warn_flag),
		.uv_fault_flag(uv_fault_flag), .pg_status_flag(pg_status_flag),
		.latched_off(latched_off));
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic b(input logic g, input logic e);
		chk(16'(g), 16'(e));
	endtask : b
	task automatic rchk(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		host.rd(c, d, ok);
		if (!ok) begin
			n_mismatch++;
			give_verdict();
		end else
			chk(d, e);
	endtask : rchk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	// program the action, drop vin, count output restarts
	task automatic fault(input logic [7:0] a, input int n, output int r,
		output int g);
		logic p;
		int k;
		int t;
		host.wr(CMD_UV_ACTION, {8'h00, a});
		vin = 16'h0300;
		p = output_enable;
		r = 0;
		g = 0;
		k = 0;
		t = 0;
		repeat (n) begin
			@(negedge clk_sys);
			k++;
			if (output_enable === 1'b1 && p !== 1'b1) begin
				r++;
				g = k - t;
				t = k;
			end
			p = output_enable;
		end
	endtask : fault
	task automatic recover;
		vin = 16'h0800;
		clear_faults = 1'b1;
		cyc(1);
		clear_faults = 1'b0;
		cyc(20);
	endtask : recover
	initial begin
		int r, g;
		vin = 16'h0800;
		vout = 16'h0000;
		unit_cycles = 16'h0004;
		{ratio_reg_enable, pg_pin_enable, clear_faults} = 3'h0;
		{clear_uv_fault_bit, other_fault} = 2'h0;
		{ctrl_pin, on_cmd} = 2'h3;
		cyc(5);
		nrst = 1'b1;
		foreach (rows[i]) begin
			rchk(rows[i].c, rows[i].r);
			host.wr(rows[i].c, rows[i].w);
			rchk(rows[i].c, rows[i].e);
		end
		$display("register test done");
		vin = 16'h0b00;
		cyc(4);
		b(ov_warn_flag, 1'b1);
		b(output_enable, 1'b1);
		vin = 16'h0500;
		cyc(4);
		b(uv_warn_flag, 1'b1);
		vin = 16'h0800;
		ratio_reg_enable = 1'b1;
		cyc(4);
		b(ratio_mode_active, 1'b1);
		ratio_reg_enable = 1'b0;
		cyc(4);
		b(ratio_mode_active, 1'b0);
		pg_pin_enable = 1'b1;
		vout = 16'h0300;
		cyc(4);
		b(output_good_signal, 1'b1);
		clear_faults = 1'b1;
		cyc(1);
		clear_faults = 1'b0;
		cyc(1);
		b(pg_status_flag, 1'b0);
		b(ov_warn_flag, 1'b0);
		vout = 16'h0100;
		cyc(4);
		b(output_good_signal, 1'b0);
		b(pg_status_flag, 1'b1);
		$display("monitor test done");
		recover();
		fault(8'h00, 40, r, g);
		b(output_enable, 1'b1);
		b(uv_fault_flag, 1'b1);
		recover();
		fault(8'hc0, 8, r, g);
		b(latched_off, 1'b1);
		vin = 16'h0800;
		cyc(8);
		b(output_enable, 1'b0);
		on_cmd = 1'b0;
		cyc(4);
		on_cmd = 1'b1;
		cyc(4);
		b(output_enable, 1'b1);
		fault(8'h80, 8, r, g);
		b(latched_off, 1'b1);
		vin = 16'h0800;
		clear_uv_fault_bit = 1'b1;
		cyc(1);
		clear_uv_fault_bit = 1'b0;
		cyc(2);
		b(output_enable, 1'b1);
		b(uv_fault_flag, 1'b0);
		recover();
		fault(8'h91, 150, r, g);
		chk(16'(r), 16'h0002);
		chk(16'(g), 16'h0008);
		b(latched_off, 1'b1);
		recover();
		fault(8'hb9, 150, r, g);
		b(r > 5, 1'b1);
		chk(16'(g), 16'h0008);
		b(latched_off, 1'b0);
		other_fault = 1'b1;
		cyc(4);
		b(output_enable, 1'b0);
		other_fault = 1'b0;
		recover();
		b(output_enable, 1'b1);
		fault(8'h42, 10, r, g);
		b(output_enable, 1'b1);
		fault(8'h42, 40, r, g);
		b(latched_off, 1'b1);
		$display("fault test done");
		// reset in mid-run drops the latch and restores the limits
		nrst = 1'b0;
		vin = 16'h0800;
		cyc(2);
		b(latched_off, 1'b0);
		nrst = 1'b1;
		cyc(1);
		b(output_enable, 1'b0);
		cyc(2);
		b(output_enable, 1'b1);
		rchk(CMD_OV_WARN, RST_OV_WARN);
		$display("reset test done");
		give_verdict();
	end
endmodule : test_vin_fault_supervisor
